// ==== hw/ifd_defines.vh ====
// field positions and format codes for the instruction format decoder
`ifndef IFD_DEFINES_VH
`define IFD_DEFINES_VH
`define IFD_EXT_PATTERN    4'hF
`define IFD_BYTE_OP_HI     15
`define IFD_BYTE_OP_LO     10
`define IFD_DEST_BIT       9
`define IFD_ACCESS_BIT     8
`define IFD_BITPOS_HI      11
`define IFD_BITPOS_LO      9
`define IFD_FMT_NONE       3'h0
`define IFD_FMT_BYTE       3'h1
`define IFD_FMT_BIT        3'h2
`define IFD_FMT_LITERAL    3'h3
`define IFD_FMT_MOVE       3'h4
`define IFD_FMT_JUMP       3'h5
`define IFD_FMT_BRANCH     3'h6
`define IFD_FMT_CONDBR     3'h7
`define IFD_OP_MOVE        4'hC
`define IFD_OP_JUMP        8'hEF
`define IFD_OP_CALL        7'h76
`define IFD_OP_BRANCH      5'h1A
`define IFD_OP_CONDBR      5'h1C
`define IFD_OP_LIT         4'h0
`endif

// ==== hw/ifd_word_class.v ====
// classifies a first instruction word into its format
`timescale 1ns/1ps
`include "ifd_defines.vh"
module ifd_word_class (
  input  wire [15:0] i_word,
  output reg  [2:0]  o_format,
  output reg         o_two_word,
  output reg         o_is_call
);
  // opcode family lookup, longest prefixes first
  always @* begin
    o_format   = `IFD_FMT_BYTE;
    o_two_word = 1'b0;
    o_is_call  = 1'b0;
    if (i_word[15:8] == `IFD_OP_JUMP) begin
      o_format   = `IFD_FMT_JUMP;
      o_two_word = 1'b1;
    end else if (i_word[15:9] == `IFD_OP_CALL) begin
      o_format   = `IFD_FMT_JUMP;
      o_two_word = 1'b1;
      o_is_call  = 1'b1;
    end else if (i_word[15:11] == `IFD_OP_BRANCH) begin
      o_format = `IFD_FMT_BRANCH;
    end else if (i_word[15:11] == `IFD_OP_CONDBR) begin
      o_format = `IFD_FMT_CONDBR;
    end else if (i_word[15:12] == `IFD_OP_MOVE) begin
      o_format   = `IFD_FMT_MOVE;
      o_two_word = 1'b1;
    end else if (i_word[15:12] == `IFD_OP_LIT) begin
      o_format = `IFD_FMT_LITERAL;
    end else if (i_word[15:14] == 2'h2 || i_word[15:14] == 2'h1) begin
      o_format = `IFD_FMT_BIT;
    end
  end
endmodule

// ==== hw/ifd_decoder.v ====
// instruction format decoder: splits program words into execution fields
// Functional notes
// RL1: byte-oriented words give opcode 15:10, destination bit 9, access bit 8, address 7:0.
// RL2: destination 0 steers the result to the working register, 1 to the file register.
// RL3: access 0 forces the access bank, 1 lets the bank select register choose the bank.
// RL4: the file-to-file move takes two words, 12-bit source then 1111 and 12-bit destination.
// RL5: bit-oriented words give opcode 15:12, bit position 11:9, access bit 8, address 7:0.
// RL6: literal words give opcode 15:8 and an 8-bit immediate in 7:0.
// RL7: the long jump forms a 20-bit target from bits 7:0 of word one and 11:0 of word two.
// RL8: the call carries a fast-return flag before target 7:0 and takes 19:8 from word two.
// RL9: the relative branch is one word with opcode 15:11 and an 11-bit offset in 10:0.
// RL10: a conditional branch is one word with opcode 15:8 and an 8-bit offset in 7:0.
// RL11: a second word is consumed as an operand extension, never decoded on its own.
`timescale 1ns/1ps
`include "ifd_defines.vh"
module ifd_decoder (
  input  wire        i_clk,
  input  wire        i_reset,
  input  wire        i_word_valid,
  input  wire [15:0] i_word,
  output reg         o_valid,
  output reg  [2:0]  o_format,
  output reg  [7:0]  o_opcode,
  output reg         o_dest_file,
  output reg         o_dest_working,
  output reg         o_use_bank_select,
  output reg         o_use_access_bank,
  output reg  [2:0]  o_bit_pos,
  output reg  [11:0] o_file_addr,
  output reg  [11:0] o_dest_addr,
  output reg  [7:0]  o_literal,
  output reg  [19:0] o_target,
  output reg         o_fast_return,
  output reg         o_is_call,
  output reg         o_ext_error
);
  wire [2:0]  cls_format;
  wire        cls_two_word;
  wire        cls_call;
  reg         pend_q;
  reg         pend_d;
  reg  [15:0] first_q;
  reg  [2:0]  pfmt_q;
  reg         pcall_q;

  ifd_word_class u_class (
    .i_word     (i_word),
    .o_format   (cls_format),
    .o_two_word (cls_two_word),
    .o_is_call  (cls_call)
  );

  // opcode field of a first word, zero-extended; the call code is one bit
  // shorter than the jump code, so the flag bit below it stays out of the opcode
  function [7:0] opcode_of;
    input [15:0] w;
    input [2:0]  fmt;
    input        call;
    begin
      case (fmt)
        `IFD_FMT_BYTE:   opcode_of = {2'h0, w[`IFD_BYTE_OP_HI:`IFD_BYTE_OP_LO]};
        `IFD_FMT_BIT:    opcode_of = {4'h0, w[15:12]};
        `IFD_FMT_MOVE:   opcode_of = {4'h0, w[15:12]};
        `IFD_FMT_BRANCH: opcode_of = {3'h0, w[15:11]};
        `IFD_FMT_JUMP:   opcode_of = call ? {1'b0, w[15:9]} : w[15:8];
        default:         opcode_of = w[15:8];
      endcase
    end
  endfunction

  // branch offsets are signed, so both widths are sign-extended into the target
  function [19:0] offset_of;
    input [15:0] w;
    input        wide;
    begin
      if (wide) begin
        offset_of = {{9{w[10]}}, w[10:0]};
      end else begin
        offset_of = {{12{w[7]}}, w[7:0]};
      end
    end
  endfunction

  // RL11 pending word tracking
  // a word after a two-word first word is always its extension, even one that
  // would itself decode as a two-word opcode, so two-word starts never nest
  always @* begin
    pend_d = pend_q;
    if (i_word_valid) begin
      pend_d = pend_q ? 1'b0 : cls_two_word;
    end
  end

  // hold first word until its extension arrives
  // kept whole: the move needs its source, the jump its low target byte
  always @(posedge i_clk) begin
    if (i_reset) begin
      pend_q  <= 1'b0;
      first_q <= 16'h0000;
      pfmt_q  <= `IFD_FMT_NONE;
      pcall_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      if (i_word_valid && !pend_q) begin
        first_q <= i_word;
        pfmt_q  <= cls_format;
        pcall_q <= cls_call;
      end
    end
  end

  // field extraction registered one cycle after the completing word
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_valid           <= 1'b0;
      o_format          <= `IFD_FMT_NONE;
      o_opcode          <= 8'h00;
      o_dest_file       <= 1'b0;
      o_dest_working    <= 1'b0;
      o_use_bank_select <= 1'b0;
      o_use_access_bank <= 1'b0;
      o_bit_pos         <= 3'h0;
      o_file_addr       <= 12'h000;
      o_dest_addr       <= 12'h000;
      o_literal         <= 8'h00;
      o_target          <= 20'h00000;
      o_fast_return     <= 1'b0;
      o_is_call         <= 1'b0;
      o_ext_error       <= 1'b0;
    end else begin
      o_valid     <= 1'b0;
      o_ext_error <= 1'b0;
      if (i_word_valid && pend_q) begin
        // RL11 second word completes pending
        o_valid     <= 1'b1;
        o_format    <= pfmt_q;
        o_is_call   <= pcall_q;
        // a call extension carries no fixed pattern, so only move and jump are checked
        o_ext_error <= (i_word[15:12] != `IFD_EXT_PATTERN) && !pcall_q;
        o_dest_file       <= 1'b0;
        o_dest_working    <= 1'b0;
        o_use_bank_select <= 1'b0;
        o_use_access_bank <= 1'b0;
        o_bit_pos         <= 3'h0;
        o_literal         <= 8'h00;
        if (pfmt_q == `IFD_FMT_MOVE) begin
          // RL4 source and destination
          o_opcode      <= opcode_of(first_q, pfmt_q, pcall_q);
          o_file_addr   <= first_q[11:0];
          o_dest_addr   <= i_word[11:0];
          o_target      <= 20'h00000;
          o_fast_return <= 1'b0;
        end else begin
          // RL7 twenty bit target
          o_opcode    <= opcode_of(first_q, pfmt_q, pcall_q);
          o_file_addr <= 12'h000;
          o_dest_addr <= 12'h000;
          o_target    <= {i_word[11:0], first_q[7:0]};
          // RL8 fast return flag
          o_fast_return <= pcall_q & first_q[8];
        end
      end else if (i_word_valid) begin
        // no pulse for the first word of a two-word instruction; its fields wait for the extension
        o_valid       <= !cls_two_word;
        o_format      <= cls_format;
        o_is_call     <= 1'b0;
        o_fast_return <= 1'b0;
        o_dest_addr   <= 12'h000;
        o_bit_pos     <= 3'h0;
        o_literal     <= 8'h00;
        o_target      <= 20'h00000;
        o_file_addr   <= {4'h0, i_word[7:0]};
        // RL3 bank selection
        o_use_bank_select <= i_word[`IFD_ACCESS_BIT];
        o_use_access_bank <= !i_word[`IFD_ACCESS_BIT];
        o_dest_file       <= 1'b0;
        o_dest_working    <= 1'b0;
        case (cls_format)
          `IFD_FMT_BYTE: begin
            // RL1 byte field split
            o_opcode <= opcode_of(i_word, cls_format, cls_call);
            // RL2 destination select
            o_dest_file    <= i_word[`IFD_DEST_BIT];
            o_dest_working <= !i_word[`IFD_DEST_BIT];
          end
          `IFD_FMT_BIT: begin
            // RL5 bit field split
            o_opcode  <= opcode_of(i_word, cls_format, cls_call);
            o_bit_pos <= i_word[`IFD_BITPOS_HI:`IFD_BITPOS_LO];
          end
          `IFD_FMT_LITERAL: begin
            // RL6 literal split
            o_opcode          <= i_word[15:8];
            o_literal         <= i_word[7:0];
            o_use_bank_select <= 1'b0;
            o_use_access_bank <= 1'b0;
            o_file_addr       <= 12'h000;
          end
          `IFD_FMT_BRANCH: begin
            // RL9 eleven bit offset
            o_opcode          <= opcode_of(i_word, cls_format, cls_call);
            o_target          <= offset_of(i_word, 1'b1);
            o_use_bank_select <= 1'b0;
            o_use_access_bank <= 1'b0;
            o_file_addr       <= 12'h000;
          end
          `IFD_FMT_CONDBR: begin
            // RL10 eight bit offset
            o_opcode          <= i_word[15:8];
            o_target          <= offset_of(i_word, 1'b0);
            o_use_bank_select <= 1'b0;
            o_use_access_bank <= 1'b0;
            o_file_addr       <= 12'h000;
          end
          default: begin
            o_opcode          <= i_word[15:8];
            o_use_bank_select <= 1'b0;
            o_use_access_bank <= 1'b0;
            o_file_addr       <= 12'h000;
          end
        endcase
      end
    end
  end
endmodule

// ==== bench/ifd_decoder_monitor.sv ====
// assertions on the instruction format decoder ports
`timescale 1ns/1ps
module ifd_decoder_monitor (
  input wire        i_clk,
  input wire        i_reset,
  input wire        i_word_valid,
  input wire [15:0] i_word,
  input wire        o_valid,
  input wire [2:0]  o_format,
  input wire [7:0]  o_opcode,
  input wire        o_dest_file,
  input wire        o_use_bank_select,
  input wire        o_use_access_bank,
  input wire [2:0]  o_bit_pos,
  input wire [11:0] o_file_addr,
  input wire [11:0] o_dest_addr,
  input wire [7:0]  o_literal,
  input wire [19:0] o_target
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // tracks whether the next word is an extension, from the pairing codes
  logic mon_pend_q;
  always @(posedge i_clk) begin
    if (i_reset) begin
      mon_pend_q <= 1'b0;
    end else if (i_word_valid) begin
      mon_pend_q <= !mon_pend_q && ((i_word[15:12] == 4'hC) || (i_word[15:8] == 8'hEF) ||
                                    (i_word[15:9] == 7'h76));
    end
  end
  // decoded byte and bit formats
  wire fb = o_valid && (o_format == 3'h1);
  wire fs = o_valid && (o_format == 3'h2);
  // two words taken back to back
  sequence s_move;
    i_word_valid && !mon_pend_q && (i_word[15:12] == 4'hC) ##1 i_word_valid;
  endsequence
  sequence s_jump;
    i_word_valid && !mon_pend_q && (i_word[15:8] == 8'hEF) ##1 i_word_valid;
  endsequence
  property p_dest;
    fb |-> o_dest_file == $past(i_word[9]);
  endproperty
  property p_bank;
    fb || fs |-> o_use_bank_select == $past(i_word[8]) && o_use_access_bank != o_use_bank_select;
  endproperty
  property p_addr;
    fb || fs |-> o_file_addr == {4'h0, $past(i_word[7:0])};
  endproperty
  property p_bit;
    fs |-> o_bit_pos == $past(i_word[11:9]) && o_opcode == {4'h0, $past(i_word[15:12])};
  endproperty
  property p_lit;
    o_valid && (o_format == 3'h3) |-> o_literal == $past(i_word[7:0]);
  endproperty
  property p_bra;
    o_valid && (o_format == 3'h6) |-> o_target == {{9{$past(i_word[10])}}, $past(i_word[10:0])};
  endproperty
  property p_hold;
    i_word_valid && !mon_pend_q && (i_word[15:12] == 4'hC) |=> !o_valid;
  endproperty
  property p_move;
    s_move |=> o_valid && o_dest_addr == $past(i_word[11:0]) && o_file_addr == $past(i_word[11:0], 2);
  endproperty
  property p_jump;
    s_jump |=> o_valid && o_target == {$past(i_word[11:0]), $past(i_word[7:0], 2)};
  endproperty
  a_dest: assert property (p_dest) else $error("dest select wrong");
  a_bank: assert property (p_bank) else $error("bank select wrong");
  a_addr: assert property (p_addr) else $error("file address wrong");
  a_bit: assert property (p_bit) else $error("bit fields wrong");
  a_lit: assert property (p_lit) else $error("literal wrong");
  a_bra: assert property (p_bra) else $error("branch offset wrong");
  a_hold: assert property (p_hold) else $error("first word decoded alone");
  a_move: assert property (p_move) else $error("move addresses wrong");
  a_jump: assert property (p_jump) else $error("jump target wrong");
endmodule
bind ifd_decoder ifd_decoder_monitor u_mon (.*);

// ==== bench/ifd_fetch_model.sv ====
// program word fetch model feeding the decoder
`timescale 1ns/1ps
module ifd_fetch_model (
  input  wire         i_clk,
  output logic        o_valid,
  output logic [15:0] o_word
);
  initial begin
    o_valid = 1'b0;
    o_word = 16'h0000;
  end
  // present a word, holding valid on when another follows
  task send(input logic [15:0] w, input logic last);
    o_valid <= 1'b1;
    o_word <= w;
    @(posedge i_clk);
    if (last) begin
      o_valid <= 1'b0;
      o_word <= ~w; // idle bus shows no stale word
    end
  endtask
endmodule

// ==== bench/tb_ifd_decoder.sv ====
// self-checking bench for the instruction format decoder
`timescale 1ns/1ps
module tb_ifd_decoder;
  logic        i_clk, i_reset, i_word_valid, o_valid, o_dest_file, o_dest_working;
  logic        o_use_bank_select, o_use_access_bank, o_fast_return, o_is_call, o_ext_error;
  logic [15:0] i_word;
  logic [2:0]  o_format, o_bit_pos;
  logic [7:0]  o_opcode, o_literal;
  logic [11:0] o_file_addr, o_dest_addr;
  logic [19:0] o_target;
  int          fails, samples_checked, cycles;
  ifd_decoder DUT (.*);
  ifd_fetch_model fm (.i_clk(i_clk), .o_valid(i_word_valid), .o_word(i_word));
  // clock and hang guard
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      wrap_up();
    end
  end
  task wrap_up;
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // n: 1 single word, 2 back to back, 3 with a gap
  task xfer(input logic [15:0] w1, input logic [15:0] w2, input int n);
    @(posedge i_clk);
    fm.send(w1, n != 2);
    if (n == 3) begin
      #1 chk("gap", {19'h0, o_valid}, 20'h0);
      @(posedge i_clk);
    end
    if (n > 1) fm.send(w2, 1'b1);
    #1 chk("valid", {19'h0, o_valid}, 20'h1);
  endtask
  task t_byte;
    for (int k = 0; k < 4; k++) begin
      xfer({6'h09, k[1:0], 8'h12}, 16'h0000, 1);
      chk("op", {o_format, o_opcode}, {3'h1, 8'h09});
      chk("dst", {o_dest_file, o_dest_working}, {k[1], !k[1]});
      chk("bank", {o_use_bank_select, o_use_access_bank}, {k[0], !k[0]});
      chk("adr", o_file_addr, 12'h012);
    end
  endtask
  task t_bit;
    for (int k = 0; k < 2; k++) begin
      xfer({4'h8, 3'h7, k[0], 8'hFF}, 16'h0000, 1);
      chk("op", {o_format, o_opcode, o_bit_pos}, {3'h2, 8'h08, 3'h7});
      chk("bank", {o_use_bank_select, o_use_access_bank}, {k[0], !k[0]});
      chk("adr", o_file_addr, 12'h0FF);
    end
  endtask
  task t_move;
    for (int n = 2; n < 4; n++) begin
      xfer(16'hC123, 16'hF456, n);
      chk("fmt", o_format, 3'h4);
      chk("src", o_file_addr, 12'h123);
      chk("dst", o_dest_addr, 12'h456);
      chk("ext", {o_ext_error, o_opcode}, {1'b0, 8'h0C});
    end
    xfer(16'hC123, 16'h0456, 2);
    chk("bad", {o_ext_error, o_format}, {1'b1, 3'h4});
  endtask
  task t_call;
    for (int s = 0; s < 2; s++) begin
      xfer({7'h76, s[0], 8'h56}, 16'hF9AB, 3);
      chk("call", {o_format, o_is_call, o_fast_return}, {3'h5, 1'b1, s[0]});
      chk("tgt", o_target, 20'h9AB56);
      chk("cop", o_opcode, 8'h76);
    end
  endtask
  // single word formats and the long jump
  task t_misc;
    xfer(16'h0E7F, 16'h0000, 1);
    chk("lit", {o_format, o_opcode, o_literal}, {3'h3, 8'h0E, 8'h7F});
    xfer(16'hEF34, 16'hF123, 2);
    chk("jmp", {o_ext_error, o_format, o_is_call, o_opcode}, {1'b0, 3'h5, 1'b0, 8'hEF});
    chk("jtg", o_target, 20'h12334);
    xfer(16'hD400, 16'h0000, 1);
    chk("bra", {o_format, o_opcode}, {3'h6, 8'h1A});
    chk("brt", o_target, 20'hFFC00);
    xfer(16'hE280, 16'h0000, 1);
    chk("cnd", {o_format, o_opcode}, {3'h7, 8'hE2});
    chk("cnt", o_target, 20'hFFF80);
  endtask
  // reset in mid-run drops a half-taken two-word instruction
  task t_reset;
    @(posedge i_clk);
    fm.send(16'hC123, 1'b1);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    #1 chk("rst", {16'h0, o_valid, o_format}, 20'h0);
    xfer(16'h0E7F, 16'h0000, 1);
    chk("new", {o_format, o_literal}, {3'h3, 8'h7F});
  endtask
  initial begin
    i_reset <= 1'b1;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    t_byte();
    t_bit();
    t_move();
    t_call();
    t_misc();
    t_reset();
    wrap_up();
  end
endmodule
